// >>> rhir_pkg.sv
// How it works
// R1: first init writes mode 0fh, 10-bit bus
// R2: c1=1 c0=1 rw=0 writes mode register
// R3: pipeline bit 1-0-1 resets pixel pipelines
// R4: load-sync bit 0-1-0 resyncs load clocks
// R5: c1=0 c0=0 rw=0 loads address pointer
// R6: pointer at mask index writes pixel mask
// R7: mask all ones passes every pixel bit
// R8: index 05h selects calibration command register
// R9: calibration low bit recalibrates each vsync
// R10: index 06h selects color format register
// R11: e0h gives 24-bit, zero pedestal, no sync
// R12: index 07h selects mux clock register
// R13: 41h gives 2:1 mux, clock/8 inverted
// R14: pointer zero aims palette at location zero
// R15: palette writes red, green, blue per location
// R16: control reads return selected register value
// R17: blue write advances palette address
package rhir_pkg;
  localparam logic [7:0] RHIR_IDX_MASK     = 8'h04;
  localparam logic [7:0] RHIR_IDX_CAL      = 8'h05;
  localparam logic [7:0] RHIR_IDX_FMT      = 8'h06;
  localparam logic [7:0] RHIR_IDX_MUX      = 8'h07;
  localparam logic [7:0] RHIR_MODE_RST     = 8'h00;
  localparam logic [7:0] RHIR_REG_RST      = 8'h00;
  localparam logic [7:0] RHIR_MASK_RST     = 8'hff;
  localparam int         RHIR_MODE_ENA_BIT = 0;
  localparam int         RHIR_MODE_BUS_BIT = 1;
  localparam int         RHIR_MODE_RES_BIT = 2;
  localparam int         RHIR_PIPE_BIT     = 0;
  localparam int         RHIR_LSYNC_BIT    = 5;
  localparam int         RHIR_CAL_BIT      = 0;
  localparam int         RHIR_FMT_LSB      = 6;
  localparam int         RHIR_PED_BIT      = 3;
  localparam int         RHIR_SYNC_BIT     = 2;
  localparam int         RHIR_MUX_LSB      = 6;
  localparam int         RHIR_DIV_LSB      = 0;
  localparam logic [1:0] RHIR_SEL_PTR      = 2'h0;
  localparam logic [1:0] RHIR_SEL_PAL      = 2'h1;
  localparam logic [1:0] RHIR_SEL_CTL      = 2'h2;
  localparam logic [1:0] RHIR_SEL_MODE     = 2'h3;
  localparam logic [1:0] RHIR_COMP_RED     = 2'h0;
  localparam logic [1:0] RHIR_COMP_GRN     = 2'h1;
  localparam logic [1:0] RHIR_COMP_BLU     = 2'h2;
endpackage

// >>> rhir_pal_mem.sv
`timescale 1ns/100ps
module rhir_pal_mem #(
  parameter int AW = 8,
  parameter int DW = 30
) (
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // read data registered, so a palette read lags the address by one clock
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> rhir_seq_det.sv
`timescale 1ns/100ps
module rhir_seq_det (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic wr,
  input  wire logic bit_in,
  input  wire logic pol,
  output logic      fire
);
  // tracks last two written values of one mode bit against the current write; pol=1 wants 1-0-1
  logic [1:0] hist_r;
  logic [1:0] cnt_r;
  logic       hit;

  assign hit = wr && (cnt_r == 2'h2) && (hist_r[1] == pol) && (hist_r[0] == !pol)
               && (bit_in == pol);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hist_r <= 2'h0;
      cnt_r  <= 2'h0;
      fire   <= 1'b0;
    end else begin
      fire <= hit;
      if (wr) begin
        hist_r <= {hist_r[0], bit_in};
        cnt_r  <= (cnt_r == 2'h2) ? cnt_r : cnt_r + 2'h1;
      end
    end
  end
endmodule

// >>> rhir_regs.sv
`timescale 1ns/100ps
module rhir_regs #(
  parameter int PAL_AW = 8,
  parameter int CW     = 10
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            host_cs,
  input  wire logic            control_select_high,
  input  wire logic            control_select_low,
  input  wire logic            host_rw,
  input  wire logic [CW-1:0]   host_wdata,
  output logic      [CW-1:0]   host_rdata,
  output logic      [7:0]      pointer_bits,
  output logic      [7:0]      pixel_mask,
  output logic      [7:0]      primary_mode,
  output logic      [7:0]      command_calibration,
  output logic      [7:0]      command_color_format,
  output logic      [7:0]      command_mux_clock,
  output logic                 pipe_reset_pulse,
  output logic                 load_resync_pulse,
  output logic                 recal_each_vsync,
  output logic                 wide_bus,
  output logic      [1:0]      color_mode,
  output logic                 pedestal_on,
  output logic                 sync_on,
  output logic      [1:0]      mux_mode,
  output logic      [5:0]      clock_div_sel
);
  initial begin
    if (PAL_AW != 8 || CW != 10) begin
      $error("rhir_regs supports an 8-bit palette address and 10-bit components only");
    end
  end

  logic [7:0]        ptr_r;
  logic [7:0]        ptr_nxt;
  logic [7:0]        mode_r;
  logic [7:0]        mask_r;
  logic [7:0]        cal_r;
  logic [7:0]        fmt_r;
  logic [7:0]        mux_r;
  logic [1:0]        comp_r;
  logic [1:0]        comp_nxt;
  logic [CW-1:0]     red_r;
  logic [CW-1:0]     grn_r;
  logic [CW-1:0]     rd_r;
  logic [3*CW-1:0]   pal_rdata;
  logic              pipe_fire;
  logic              lsync_fire;

  wire logic [1:0] sel      = {control_select_high, control_select_low};
  wire logic       wr_ptr   = host_cs && !host_rw && (sel == rhir_pkg::RHIR_SEL_PTR);   // R5
  wire logic       wr_mode  = host_cs && !host_rw && (sel == rhir_pkg::RHIR_SEL_MODE);  // R2
  wire logic       wr_ctl   = host_cs && !host_rw && (sel == rhir_pkg::RHIR_SEL_CTL);
  wire logic       wr_pal   = host_cs && !host_rw && (sel == rhir_pkg::RHIR_SEL_PAL);   // R15
  wire logic       wr_mask  = wr_ctl && (ptr_r == rhir_pkg::RHIR_IDX_MASK);             // R6
  wire logic       wr_cal   = wr_ctl && (ptr_r == rhir_pkg::RHIR_IDX_CAL);              // R8
  wire logic       wr_fmt   = wr_ctl && (ptr_r == rhir_pkg::RHIR_IDX_FMT);              // R10
  wire logic       wr_mux   = wr_ctl && (ptr_r == rhir_pkg::RHIR_IDX_MUX);              // R12
  wire logic       blue_wr  = wr_pal && (comp_r == rhir_pkg::RHIR_COMP_BLU);
  wire logic [7:0] wbyte    = host_wdata[7:0];

  function automatic logic [7:0] ctl_value(input logic [7:0] idx, input logic [7:0] m,
                                           input logic [7:0] c1, input logic [7:0] c2,
                                           input logic [7:0] c3);
    ctl_value = (idx == rhir_pkg::RHIR_IDX_MASK) ? m  :
                (idx == rhir_pkg::RHIR_IDX_CAL)  ? c1 :
                (idx == rhir_pkg::RHIR_IDX_FMT)  ? c2 :
                (idx == rhir_pkg::RHIR_IDX_MUX)  ? c3 : 8'h00;
  endfunction

  // pointer doubles as palette address; blue write steps it so loops need no rewrite
  assign ptr_nxt  = wr_ptr ? wbyte : (blue_wr ? ptr_r + 8'h01 : ptr_r);  // R14 R17
  assign comp_nxt = wr_ptr ? rhir_pkg::RHIR_COMP_RED :
                    (wr_pal ? (blue_wr ? rhir_pkg::RHIR_COMP_RED : comp_r + 2'h1) : comp_r);

  wire logic [CW-1:0] pal_comp = (comp_r == rhir_pkg::RHIR_COMP_RED) ? pal_rdata[3*CW-1:2*CW] :
                                 (comp_r == rhir_pkg::RHIR_COMP_GRN) ? pal_rdata[2*CW-1:CW] :
                                 pal_rdata[CW-1:0];
  wire logic [CW-1:0] rd_nxt = (sel == rhir_pkg::RHIR_SEL_PTR)  ? {2'h0, ptr_r} :
                               (sel == rhir_pkg::RHIR_SEL_MODE) ? {2'h0, mode_r} :
                               (sel == rhir_pkg::RHIR_SEL_CTL)  ?
                               {2'h0, ctl_value(ptr_r, mask_r, cal_r, fmt_r, mux_r)} :
                               pal_comp;  // R16

  rhir_pal_mem #(.AW(PAL_AW), .DW(3*CW)) u_pal (
    .core_clk (core_clk),
    .we       (blue_wr),
    .waddr    (ptr_r),
    .wdata    ({red_r, grn_r, host_wdata}),
    .raddr    (ptr_r),
    .rdata    (pal_rdata)
  );

  rhir_seq_det u_pipe (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr       (wr_mode),
    .bit_in   (wbyte[rhir_pkg::RHIR_PIPE_BIT]),
    .pol      (1'b1),
    .fire     (pipe_fire)
  );  // R3

  rhir_seq_det u_lsync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr       (wr_mode),
    .bit_in   (wbyte[rhir_pkg::RHIR_LSYNC_BIT]),
    .pol      (1'b0),
    .fire     (lsync_fire)
  );  // R4

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_r  <= 8'h00;
      comp_r <= rhir_pkg::RHIR_COMP_RED;
      mode_r <= rhir_pkg::RHIR_MODE_RST;
      mask_r <= rhir_pkg::RHIR_MASK_RST;
      cal_r  <= rhir_pkg::RHIR_REG_RST;
      fmt_r  <= rhir_pkg::RHIR_REG_RST;
      mux_r  <= rhir_pkg::RHIR_REG_RST;
      red_r  <= '0;
      grn_r  <= '0;
      rd_r   <= '0;
    end else begin
      ptr_r  <= ptr_nxt;
      comp_r <= comp_nxt;
      rd_r   <= rd_nxt;
      if (wr_mode) begin
        mode_r <= wbyte;  // R1 R2
      end
      if (wr_mask) begin
        mask_r <= wbyte;  // R6 R7
      end
      if (wr_cal) begin
        cal_r <= wbyte;  // R9
      end
      if (wr_fmt) begin
        fmt_r <= wbyte;  // R11
      end
      if (wr_mux) begin
        mux_r <= wbyte;  // R13
      end
      if (wr_pal && comp_r == rhir_pkg::RHIR_COMP_RED) begin
        red_r <= host_wdata;  // R15
      end
      if (wr_pal && comp_r == rhir_pkg::RHIR_COMP_GRN) begin
        grn_r <= host_wdata;
      end
    end
  end

  assign host_rdata           = rd_r;
  assign pointer_bits         = ptr_r;
  assign pixel_mask           = mask_r;
  assign primary_mode         = mode_r;
  assign command_calibration  = cal_r;
  assign command_color_format = fmt_r;
  assign command_mux_clock    = mux_r;
  assign pipe_reset_pulse     = pipe_fire;
  assign load_resync_pulse    = lsync_fire;
  // decoded fields come from flops above; 8'h0f sets bus and resolution bits
  assign recal_each_vsync     = cal_r[rhir_pkg::RHIR_CAL_BIT];  // R9
  assign wide_bus             = mode_r[rhir_pkg::RHIR_MODE_BUS_BIT];  // R1
  assign color_mode           = fmt_r[rhir_pkg::RHIR_FMT_LSB +: 2];  // R11
  assign pedestal_on          = fmt_r[rhir_pkg::RHIR_PED_BIT];
  assign sync_on              = fmt_r[rhir_pkg::RHIR_SYNC_BIT];
  assign mux_mode             = mux_r[rhir_pkg::RHIR_MUX_LSB +: 2];  // R13
  assign clock_div_sel        = mux_r[rhir_pkg::RHIR_DIV_LSB +: 6];

  a_mode_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mode |=> primary_mode == $past(wbyte)) else $error("mode write lost");  // R2
  a_ptr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ptr |=> pointer_bits == $past(wbyte)) else $error("pointer load lost");  // R5
  a_mask_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mask |=> pixel_mask == $past(wbyte)) else $error("mask write lost");  // R6
  a_mask_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_mask |=> $stable(pixel_mask)) else $error("mask changed unasked");  // R7
  a_cal_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_cal |=> recal_each_vsync == $past(wbyte[0])) else $error("calibrate bit wrong");  // R9
  a_fmt_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_fmt |=> command_color_format == $past(wbyte)) else $error("format write lost");  // R10
  a_mux_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mux |=> command_mux_clock == $past(wbyte)) else $error("mux write lost");  // R12
  a_blue_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    blue_wr && !wr_ptr |=> pointer_bits == $past(pointer_bits) + 8'h01)
    else $error("palette address not advanced");  // R17
  // host accesses are spaced, so key on a format read rather than write-then-read
  a_ctl_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (host_cs && host_rw && sel == rhir_pkg::RHIR_SEL_CTL && ptr_r == rhir_pkg::RHIR_IDX_FMT)
    |=> host_rdata[7:0] == $past(command_color_format)) else $error("readback wrong");  // R16
  a_pipe_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
    pipe_reset_pulse |-> $past(wr_mode)) else $error("pipe reset without write");  // R3

  c_init_mode: cover property (@(posedge core_clk) wr_mode && wbyte == 8'h0f);
  c_pipe_rst: cover property (@(posedge core_clk) pipe_reset_pulse);
  c_lsync: cover property (@(posedge core_clk) load_resync_pulse);
  c_pal_loc: cover property (@(posedge core_clk) blue_wr);
endmodule

// >>> rhir_host_model.sv
`timescale 1ns/100ps
module rhir_host_model (
  input  wire logic       core_clk,
  output logic            host_cs,
  output logic            control_select_high,
  output logic            control_select_low,
  output logic            host_rw,
  output logic      [9:0] host_wdata
);
  initial begin
    host_cs = 1'b0;
    {control_select_high, control_select_low} = 2'h0;
    host_rw = 1'b1;
    host_wdata = 10'h155;
  end
  // selects and rw stay put after release so registered read data can settle
  task automatic xfer(input logic [1:0] sel, input logic rw, input logic [9:0] d);
    @(negedge core_clk);
    host_cs = 1'b1;
    {control_select_high, control_select_low} = sel;
    host_rw = rw;
    host_wdata = d;
    @(posedge core_clk);
    @(negedge core_clk);
    host_cs = 1'b0;
    host_wdata = ~d; // released bus never shows a stale value
  endtask
endmodule

// >>> ramdac_host_init_registers_tb.sv
`timescale 1ns/100ps
module ramdac_host_init_registers_tb;
  localparam logic [1:0] SP = rhir_pkg::RHIR_SEL_PTR;
  localparam logic [1:0] SA = rhir_pkg::RHIR_SEL_PAL;
  localparam logic [1:0] SC = rhir_pkg::RHIR_SEL_CTL;
  localparam logic [1:0] SM = rhir_pkg::RHIR_SEL_MODE;
  typedef struct packed {logic [1:0] s; logic [7:0] d; logic [2:0] o; logic [7:0] e;} rhir_row_t;
  logic core_clk = 1'b0, rst_n = 1'b0, cs, csh, csl, rw, pp, lp, rv, wb, pe, sy;
  logic [9:0] wd, rd;
  logic [7:0] ptr, msk, md, cal, fmt, mux;
  logic [1:0] cm, mm;
  logic [5:0] dv;
  int fail_count = 0, check_count = 0, pipe_n = 0, sync_n = 0;
  logic [9:0] pal [6] = '{10'h3a5, 10'h0c3, 10'h21e, 10'h1f0, 10'h2b4, 10'h07d};
  rhir_row_t rows [14] = '{'{SM, 8'h0f, 3'h0, 8'h0f}, '{SM, 8'h0e, 3'h0, 8'h0e},
    '{SM, 8'h0f, 3'h0, 8'h0f}, '{SM, 8'h2f, 3'h0, 8'h2f}, '{SM, 8'h0f, 3'h0, 8'h0f},
    '{SP, 8'h04, 3'h1, 8'h04}, '{SC, 8'h5a, 3'h2, 8'h5a}, '{SC, 8'hff, 3'h2, 8'hff},
    '{SP, 8'h05, 3'h1, 8'h05}, '{SC, 8'h01, 3'h3, 8'h01}, '{SP, 8'h06, 3'h1, 8'h06},
    '{SC, 8'he0, 3'h4, 8'he0}, '{SP, 8'h07, 3'h1, 8'h07}, '{SC, 8'h41, 3'h5, 8'h41}};
  always #50 core_clk = ~core_clk;
  rhir_host_model host_u (.core_clk(core_clk), .host_cs(cs), .control_select_high(csh),
    .control_select_low(csl), .host_rw(rw), .host_wdata(wd));
  rhir_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .host_cs(cs),
    .control_select_high(csh), .control_select_low(csl), .host_rw(rw), .host_wdata(wd),
    .host_rdata(rd), .pointer_bits(ptr), .pixel_mask(msk), .primary_mode(md),
    .command_calibration(cal), .command_color_format(fmt), .command_mux_clock(mux),
    .pipe_reset_pulse(pp), .load_resync_pulse(lp), .recal_each_vsync(rv), .wide_bus(wb),
    .color_mode(cm), .pedestal_on(pe), .sync_on(sy), .mux_mode(mm), .clock_div_sel(dv));
  always @(posedge core_clk) begin
    if (pp === 1'b1) pipe_n++;
    if (lp === 1'b1) sync_n++;
  end
  function automatic logic [7:0] obs(input logic [2:0] o);
    case (o)
      3'h0: return md;
      3'h1: return ptr;
      3'h2: return msk;
      3'h3: return cal;
      3'h4: return fmt;
      default: return mux;
    endcase
  endfunction
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [1:0] s, input int n, input logic [9:0] exp);
    host_u.xfer(s, 1'b1, 10'h000);
    repeat (n) @(negedge core_clk);
    chk(rd, exp);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(negedge core_clk);
    chk(10'(msk), 10'h0ff);
    chk(10'({md, 2'h0}), 10'h000);
    chk(10'({ptr, 2'h0}), 10'h000);
    chk(10'({cal, 2'h0}), 10'h000);
    chk(10'({fmt, 2'h0}), 10'h000);
    chk(10'({mux, 2'h0}), 10'h000);
    chk(rd, 10'h000);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      host_u.xfer(rows[i].s, 1'b0, 10'(rows[i].d));
      chk(10'(obs(rows[i].o)), 10'(rows[i].e));
    end
    chk(10'({pipe_n[1:0], sync_n[1:0]}), 10'h005);
    chk(10'({wb, rv, cm, pe, sy}), 10'b11_1100);
    chk(10'({mm, dv}), 10'h41);
    rd_chk(SC, 1, 10'h041);
    host_u.xfer(SP, 1'b0, 10'h006);
    rd_chk(SC, 1, 10'h0e0);
    host_u.xfer(SP, 1'b0, 10'h008);
    host_u.xfer(SC, 1'b0, 10'h05a);
    rd_chk(SC, 1, 10'h000);
    chk(10'({msk, fmt[1:0]}), 10'h3fc);
    host_u.xfer(SP, 1'b0, 10'h000);
    for (int i = 0; i < 6; i++) begin
      host_u.xfer(SA, 1'b0, pal[i]);
      if (i % 3 == 2) chk(10'(ptr), 10'(i / 3 + 1));
    end
    for (int j = 0; j < 2; j++) begin
      host_u.xfer(SP, 1'b0, 10'(j));
      rd_chk(SA, 2, pal[3 * j]);
    end
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    chk(10'({msk, fmt[1:0]}), 10'h3fc);
    chk(10'(fmt), 10'h000);
    complete_run;
  end
endmodule
